//--- core/otr_defs.svh
// Register offsets, field positions, reset values and timing constants
`ifndef OTR_DEFS_SVH
`define OTR_DEFS_SVH

`define OTR_CMD_CFG      8'h50
`define OTR_CMD_CLEAR    8'h03
`define OTR_CFG_RESET    8'hC0
`define OTR_RESP_MSB     7
`define OTR_RESP_LSB     6
`define OTR_RETRY_MSB    5
`define OTR_RETRY_LSB    3
`define OTR_DELAY_MSB    2
`define OTR_DELAY_LSB    0
`define OTR_RETRY_NONE   3'h0
`define OTR_RETRY_FOREVR 3'h7
`define OTR_UNIT_MIN     16'h0001

`endif

//--- core/otr_pkg.sv
// Types and shared arithmetic for the over-temperature fault response block
package otr_pkg;

  typedef enum logic [1:0] {
    OTR_RESP_IGNORE,
    OTR_RESP_OPERATE,
    OTR_RESP_DISABLE,
    OTR_RESP_LATCH
  } otr_resp_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
    logic [7:0] data;
  } otr_cmd_type;

  typedef enum logic [2:0] {
    OTR_NORMAL,
    OTR_DELAY_RUN,
    OTR_OFF_WAIT,
    OTR_LATCHED,
    OTR_OFF_CMD
  } otr_state_type;

  // Delay code n means 2**n time units
  function automatic logic [7:0] otr_units_f(input logic [2:0] code);
    otr_units_f = 8'h01 << code;
  endfunction : otr_units_f

endpackage : otr_pkg

//--- core/otr_delay_timer.sv
// Delay timer counting 2**n time units of a programmable cycle length
`include "otr_defs.svh"
module otr_delay_timer (
  input  wire logic        clock,       // System clock
  input  wire logic        rst_n,       // Async reset, active low
  input  wire logic        start,       // Restart the delay
  input  wire logic        stop,        // Abandon the delay
  input  wire logic [15:0] unit_cycles, // Cycles per time unit
  input  wire logic [2:0]  delay_code,  // Exponent of unit count
  output logic             done         // One-cycle expiry pulse
);
  import otr_pkg::*;

  logic        running;
  logic        next_running;
  logic [15:0] div_cnt;
  logic [15:0] next_div_cnt;
  logic [7:0]  unit_cnt;
  logic [7:0]  next_unit_cnt;
  logic        next_done;
  logic [15:0] unit_len;

  // Zero unit length would never tick, so treat it as one cycle
  assign unit_len = (unit_cycles == 16'h0000) ? `OTR_UNIT_MIN : unit_cycles;

  // Divider gives a unit tick, unit counter counts to 2**n
  always_comb begin
    next_running  = running;
    next_div_cnt  = div_cnt;
    next_unit_cnt = unit_cnt;
    next_done     = 1'b0;
    if (start) begin
      next_running  = 1'b1;
      next_div_cnt  = 16'h0000;
      next_unit_cnt = 8'h00;
    end else if (stop) begin
      next_running = 1'b0;
    end else if (running) begin
      if (div_cnt == unit_len - `OTR_UNIT_MIN) begin
        next_div_cnt = 16'h0000;
        if (unit_cnt == otr_units_f(delay_code) - 8'h01) begin
          next_running = 1'b0;
          next_done    = 1'b1;
        end else begin
          next_unit_cnt = unit_cnt + 8'h01;
        end
      end else begin
        next_div_cnt = div_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      running  <= 1'b0;
      div_cnt  <= 16'h0000;
      unit_cnt <= 8'h00;
      done     <= 1'b0;
    end else begin
      running  <= next_running;
      div_cnt  <= next_div_cnt;
      unit_cnt <= next_unit_cnt;
      done     <= next_done;
    end
  end

  a_span_four_units: assert property (@(posedge clock) disable iff (!rst_n)
    (start && unit_cycles == 16'h0001 && delay_code == 3'h2) ##1
    (!start && !stop && unit_cycles == 16'h0001 && delay_code == 3'h2)[*4] |=> done)
    else $error("four-unit delay did not expire on time");

  a_span_scaled: assert property (@(posedge clock) disable iff (!rst_n)
    (start && unit_cycles == 16'h0002 && delay_code == 3'h1) ##1
    (!start && !stop && unit_cycles == 16'h0002 && delay_code == 3'h1)[*4] |-> !done ##1 done)
    else $error("scaled delay expiry misplaced");

endmodule : otr_delay_timer

//--- core/otr_fault_response.sv
// Over-temperature fault response controller with its configuration register
// Operation
// - Response 00 ignores the fault; output keeps running.
// - Response 01 keeps operating for the decoded delay after fault detection.
// - Response 01: fault still present at delay end, then apply retry setting.
// - Response 10 disables output at once, then applies retry setting.
// - Response 11 holds output off until the fault is cleared.
// - Retry setting 000 makes no restart; output off until cleared.
// - Retry settings 1 to 6 restart that often, then latch off.
// - Restart attempts start one decoded delay apart.
// - Retry setting 111 retries forever until commanded off or shut down.
// - Delay code n means 2 to the power n time units.
// - One decoded delay serves both operating delay and retry spacing.
// - Time unit length comes from a separate register outside this block.
`include "otr_defs.svh"
module otr_fault_response (
  input  wire logic                clock,           // System clock, 25 MHz
  input  wire logic                rst_n,           // Async reset, active low
  input  wire otr_pkg::otr_cmd_type cmd,            // Management command strobe
  input  wire logic [15:0]         unit_cycles,     // Time unit length in cycles
  input  wire logic                over_temp_fault, // Over-temperature present
  input  wire logic                clear_status,    // Clear status bit pulse
  input  wire logic                run_cmd,         // Output on command level
  input  wire logic                other_shutdown,  // Another fault forces off
  output logic                     output_enable,   // Power stage enable
  output logic                     fault_flag,      // Sticky fault status
  output logic [7:0]               response_config, // Configuration readback
  output logic [2:0]               attempt_count,   // Failed restart attempts
  output otr_pkg::otr_state_type   state            // Controller state
);
  import otr_pkg::*;

  logic [7:0]    next_config;
  otr_state_type next_state;
  logic [2:0]    next_attempts;
  logic          next_enable;
  logic          next_flag;
  logic          timer_start;
  logic          timer_stop;
  logic          timer_done;
  logic          clear_req;
  logic          allowed;
  otr_resp_type  resp;
  logic [2:0]    retries;
  logic [2:0]    delay_code;

  assign resp       = otr_resp_type'(response_config[`OTR_RESP_MSB:`OTR_RESP_LSB]);
  assign retries    = response_config[`OTR_RETRY_MSB:`OTR_RETRY_LSB];
  assign delay_code = response_config[`OTR_DELAY_MSB:`OTR_DELAY_LSB];
  assign clear_req  = clear_status || (cmd.valid && cmd.code == `OTR_CMD_CLEAR);
  assign allowed    = run_cmd && !other_shutdown;

  // Configuration register, written by command code
  always_comb begin
    next_config = response_config;
    if (cmd.valid && cmd.code == `OTR_CMD_CFG) begin
      next_config = cmd.data;
    end
  end

  // Fault handling sequence
  always_comb begin
    next_state    = state;
    next_attempts = attempt_count;
    timer_start   = 1'b0;
    timer_stop    = 1'b0;
    if (!allowed) begin
      // Command off or other shutdown ends any retrying
      next_state = OTR_OFF_CMD;
      timer_stop = 1'b1;
    end else begin
      case (state)
        OTR_OFF_CMD: begin
          next_state    = OTR_NORMAL;
          next_attempts = 3'h0;
        end
        OTR_NORMAL: begin
          if (over_temp_fault) begin
            case (resp)
              OTR_RESP_IGNORE: next_state = OTR_NORMAL;
              OTR_RESP_OPERATE: begin
                next_state  = OTR_DELAY_RUN;
                timer_start = 1'b1;
              end
              OTR_RESP_DISABLE: begin
                if (retries == `OTR_RETRY_NONE) begin
                  next_state = OTR_LATCHED;
                end else begin
                  next_state  = OTR_OFF_WAIT;
                  timer_start = 1'b1;
                end
              end
              default: next_state = OTR_LATCHED;
            endcase
          end
        end
        OTR_DELAY_RUN: begin
          if (clear_req) begin
            next_state = OTR_NORMAL;
            timer_stop = 1'b1;
          end else if (timer_done) begin
            if (!over_temp_fault) begin
              next_state = OTR_NORMAL;
            end else if (retries == `OTR_RETRY_NONE) begin
              next_state = OTR_LATCHED;
            end else begin
              next_state  = OTR_OFF_WAIT;
              timer_start = 1'b1;
            end
          end
        end
        OTR_OFF_WAIT: begin
          if (clear_req) begin
            next_state    = OTR_NORMAL;
            next_attempts = 3'h0;
            timer_stop    = 1'b1;
          end else if (timer_done) begin
            if (!over_temp_fault) begin
              // Restart succeeded, next fault gets a fresh budget
              next_state    = OTR_NORMAL;
              next_attempts = 3'h0;
            end else if (retries != `OTR_RETRY_FOREVR && attempt_count + 3'h1 >= retries) begin
              next_state = OTR_LATCHED;
            end else begin
              // Saturate so endless retry never wraps the count
              if (attempt_count != 3'h7) begin
                next_attempts = attempt_count + 3'h1;
              end
              timer_start = 1'b1;
            end
          end
        end
        OTR_LATCHED: begin
          if (clear_req) begin
            next_state    = OTR_NORMAL;
            next_attempts = 3'h0;
          end
        end
        default: next_state = OTR_OFF_CMD;
      endcase
    end
  end

  // Output enable and sticky flag; a new fault wins over a clear
  always_comb begin
    next_enable = (next_state == OTR_NORMAL) || (next_state == OTR_DELAY_RUN);
    next_flag   = fault_flag && !clear_req;
    if (state == OTR_NORMAL && allowed && over_temp_fault && resp != OTR_RESP_IGNORE) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      response_config <= `OTR_CFG_RESET;
      state           <= OTR_OFF_CMD;
      attempt_count   <= 3'h0;
      output_enable   <= 1'b0;
      fault_flag      <= 1'b0;
    end else begin
      response_config <= next_config;
      state           <= next_state;
      attempt_count   <= next_attempts;
      output_enable   <= next_enable;
      fault_flag      <= next_flag;
    end
  end

  // Shared delay for operating window and retry spacing
  otr_delay_timer u_timer (
    .clock       (clock),
    .rst_n       (rst_n),
    .start       (timer_start),
    .stop        (timer_stop),
    .unit_cycles (unit_cycles),
    .delay_code  (delay_code),
    .done        (timer_done)
  );

  a_ignore_stays_on: assert property (@(posedge clock) disable iff (!rst_n)
    (state == OTR_NORMAL && resp == OTR_RESP_IGNORE && allowed) |=> output_enable && state == OTR_NORMAL)
    else $error("ignored fault interrupted output");

  a_operate_delay: assert property (@(posedge clock) disable iff (!rst_n)
    (state == OTR_NORMAL && over_temp_fault && resp == OTR_RESP_OPERATE && allowed)
    |=> output_enable && state == OTR_DELAY_RUN)
    else $error("operate response did not keep output on");

  a_operate_expiry: assert property (@(posedge clock) disable iff (!rst_n)
    (state == OTR_DELAY_RUN && timer_done && over_temp_fault && !clear_req && allowed
     && retries != `OTR_RETRY_NONE) |=> !output_enable && state == OTR_OFF_WAIT)
    else $error("fault at delay end did not start retries");

  a_disable_at_once: assert property (@(posedge clock) disable iff (!rst_n)
    (state == OTR_NORMAL && over_temp_fault && resp == OTR_RESP_DISABLE && allowed) |=> !output_enable)
    else $error("disable response left output on");

  a_latch_holds: assert property (@(posedge clock) disable iff (!rst_n)
    (state == OTR_LATCHED && !clear_req && allowed) |=> state == OTR_LATCHED && !output_enable)
    else $error("latched fault released without clear");

  a_no_retry: assert property (@(posedge clock) disable iff (!rst_n)
    (state == OTR_NORMAL && over_temp_fault && resp == OTR_RESP_DISABLE
     && retries == `OTR_RETRY_NONE && allowed) |=> state == OTR_LATCHED)
    else $error("zero retry setting restarted");

  a_retry_limit: assert property (@(posedge clock) disable iff (!rst_n)
    (state == OTR_OFF_WAIT && timer_done && over_temp_fault && !clear_req && allowed
     && retries != `OTR_RETRY_FOREVR && attempt_count + 3'h1 >= retries) |=> state == OTR_LATCHED)
    else $error("retry budget exceeded");

  a_retry_forever: assert property (@(posedge clock) disable iff (!rst_n)
    (state == OTR_OFF_WAIT && timer_done && over_temp_fault && !clear_req && allowed
     && retries == `OTR_RETRY_FOREVR) |=> state == OTR_OFF_WAIT)
    else $error("endless retry stopped");

  a_cmd_off: assert property (@(posedge clock) disable iff (!rst_n)
    !allowed |=> !output_enable && state == OTR_OFF_CMD)
    else $error("off command did not stop output");

  a_fresh_count: assert property (@(posedge clock) disable iff (!rst_n)
    (state == OTR_LATCHED && clear_req && allowed) |=> attempt_count == 3'h0 && output_enable)
    else $error("clear did not restart sequence");

endmodule : otr_fault_response

//--- sim/otr_host_model.sv
// Management bus host model issuing configuration and clear commands
module otr_host_model (
  input  wire logic          clock, // System clock
  output otr_pkg::otr_cmd_type cmd  // Command strobe to the block
);
  timeunit 1ns;
  timeprecision 1ps;
  import otr_pkg::*;

  // Idle bus carries no valid command
  initial cmd = '0;

  // One strobe per command; released lines show inverted data, not stale data
  task automatic send(input logic [7:0] code, input logic [7:0] data);
    @(negedge clock);
    cmd = '{valid: 1'b1, code: code, data: data};
    @(negedge clock);
    cmd = '{valid: 1'b0, code: ~code, data: ~data};
  endtask : send
endmodule : otr_host_model

//--- sim/tb_otr_fault_response.sv
// Self-checking bench for the over-temperature fault response controller
module tb_otr_fault_response;
  timeunit 1ns;
  timeprecision 1ps;
  import otr_pkg::*;

  logic          clock = 1'b0;
  logic          rst_n = 1'b0;
  logic          fault = 1'b0;
  logic          clr   = 1'b0;
  logic          run   = 1'b1;
  logic          shut  = 1'b0;
  logic [15:0]   unit  = 16'h0001;
  otr_cmd_type   cmd;
  logic          en;
  logic          flag;
  logic [7:0]    cfg;
  logic [2:0]    attempts;
  otr_state_type st;
  int            err_count    = 0;
  int            total_checks = 0;
  int            cycles       = 0;

  // 25 MHz clock
  always #20 clock = ~clock;

  otr_host_model HOST (.clock(clock), .cmd(cmd));

  otr_fault_response DUT (
    .clock(clock), .rst_n(rst_n), .cmd(cmd), .unit_cycles(unit), .over_temp_fault(fault),
    .clear_status(clr), .run_cmd(run), .other_shutdown(shut), .output_enable(en),
    .fault_flag(flag), .response_config(cfg), .attempt_count(attempts), .state(st));

  task automatic chk_bit(input logic g, input logic e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk_bit

  task automatic chk_val(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk_val

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  // Program, clear any latched fault, and confirm output running
  task automatic prep(input logic [7:0] c);
    fault = 1'b0;
    HOST.send(8'h50, c);
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(2);
    chk_val(cfg, c);
    chk_bit(en, 1'b1);
  endtask : prep

  task automatic wait_st(input otr_state_type s, input int lim, output int n);
    n = 0;
    while (st !== s && n < lim) begin
      cyc(1);
      n++;
    end
  endtask : wait_st

  task automatic t_ignore;
    prep(8'h00);
    fault = 1'b1;
    repeat (40) begin
      cyc(1);
      chk_bit(en, 1'b1);
    end
    chk_bit(flag, 1'b0);
    $display("ignore test done");
  endtask : t_ignore

  // Operate on for 128 units of one cycle, then latch with no retry
  task automatic t_operate;
    prep(8'h47);
    fault = 1'b1;
    cyc(129);
    chk_bit(en, 1'b1);
    cyc(1);
    chk_bit(en, 1'b0);
    cyc(4);
    chk_val({5'h0, st}, {5'h0, OTR_LATCHED});
    fault = 1'b0;
    cyc(20);
    chk_bit(en, 1'b0);
    HOST.send(8'h03, 8'h00);
    cyc(2);
    chk_bit(en, 1'b1);
    $display("operate test done");
  endtask : t_operate

  // Retries 1..6 with delay codes 1..6 and a two-cycle unit
  task automatic t_retry;
    int n;
    int d;
    for (int r = 1; r <= 6; r++) begin
      unit = 16'h0002;
      d = (2 ** r) * 2;
      prep(8'h80 | 8'(r << 3) | 8'(r));
      fault = 1'b1;
      cyc(2);
      chk_bit(en, 1'b0);
      wait_st(OTR_LATCHED, 2000, n);
      chk_bit(n >= r * d - 2 && n <= r * (d + 2) + 3, 1'b1);
      fault = 1'b0;
      cyc(5);
      chk_bit(en, 1'b0);
    end
    unit = 16'h0001;
    prep(8'h88);
    fault = 1'b1;
    cyc(1);
    fault = 1'b0;
    wait_st(OTR_NORMAL, 20, n);
    chk_bit(en, 1'b1);
    $display("retry test done");
  endtask : t_retry

  task automatic t_forever;
    logic seen;
    seen = 1'b0;
    prep(8'hBA);
    fault = 1'b1;
    repeat (200) begin
      cyc(1);
      seen = seen | (st === OTR_LATCHED);
    end
    chk_bit(seen, 1'b0);
    chk_val({5'h0, attempts}, 8'h07);
    run = 1'b0;
    cyc(2);
    chk_val({5'h0, st}, {5'h0, OTR_OFF_CMD});
    chk_bit(en, 1'b0);
    fault = 1'b0;
    run = 1'b1;
    cyc(3);
    chk_bit(en, 1'b1);
    chk_val({5'h0, attempts}, 8'h00);
    $display("forever test done");
  endtask : t_forever

  // Latch-off, refused code, forced shutdown, clear by status bit
  task automatic t_latch;
    prep(8'hC0);
    HOST.send(8'h51, 8'h3F);
    cyc(1);
    chk_val(cfg, 8'hC0);
    fault = 1'b1;
    cyc(3);
    chk_bit(en, 1'b0);
    chk_bit(flag, 1'b1);
    fault = 1'b0;
    cyc(10);
    chk_bit(en, 1'b0);
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(2);
    chk_bit(en, 1'b1);
    chk_bit(flag, 1'b0);
    shut = 1'b1;
    cyc(2);
    chk_bit(en, 1'b0);
    shut = 1'b0;
    cyc(3);
    chk_bit(en, 1'b1);
    $display("latch test done");
  endtask : t_latch

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  // Cut a hang short
  always @(posedge clock) begin
    cycles++;
    if (cycles >= 20000) begin
      err_count++;
      print_verdict();
    end
  end

  initial begin
    cyc(6);
    chk_val(cfg, 8'hC0);
    chk_bit(en, 1'b0);
    cyc(6);
    rst_n = 1'b1;
    cyc(2);
    chk_bit(en, 1'b1);
    $display("reset test done");
    t_ignore();
    t_operate();
    t_retry();
    t_forever();
    t_latch();
    print_verdict();
  end
endmodule : tb_otr_fault_response
